// [rtl/sme_defines.svh]
// Purpose: constants for the shift/move/indirect execution block
// Assumes: 8-bit data path, 7-bit file operand, 16-bit pointers
// Notes:   included by its bare name
`ifndef SME_DEFINES_SVH
`define SME_DEFINES_SVH

// ----------------------------------------------------------------
// file operand map
// ----------------------------------------------------------------
`define SME_FILE_ADDR_MAX    7'h7f
`define SME_INDIRECT_PORT0   7'h00
`define SME_INDIRECT_PORT1   7'h01

// ----------------------------------------------------------------
// pointer update kind codes
// ----------------------------------------------------------------
`define SME_KIND_PRE_INC     2'h0
`define SME_KIND_PRE_DEC     2'h1
`define SME_KIND_POST_INC    2'h2
`define SME_KIND_POST_DEC    2'h3

// ----------------------------------------------------------------
// reset values, pointer step and destination codes
// ----------------------------------------------------------------
`define SME_ACC_RESET        8'h00
`define SME_PTR_RESET        16'h0000
`define SME_PTR_STEP         16'h0001
`define SME_DEST_ACC         1'b0
`define SME_DEST_FILE        1'b1

`endif

// [rtl/sme_pkg.sv]
// Purpose: types for the shift/move/indirect execution block
// Assumes: constants live in sme_defines.svh
// Notes:   nothing here is imported; use sme_pkg::name
`default_nettype none
package sme_pkg;

  // ----------------------------------------------------------------
  // instruction select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SME_OP_OR_ACC_INTO_FILE    = 3'h0,
    SME_OP_SHIFT_LEFT_LOGICAL  = 3'h1,
    SME_OP_SHIFT_RIGHT_LOGICAL = 3'h2,
    SME_OP_COPY_FILE_OPERAND   = 3'h3,
    SME_OP_LOAD_ACC_INDIRECT   = 3'h4
  } sme_op_type;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SME_ST_IDLE = 2'b01,
    SME_ST_EXEC = 2'b10
  } sme_state_type;

endpackage

`default_nettype wire

// [rtl/sme_exec.sv]
// Purpose: executes five core instructions on an external file register array
// Assumes: file array answers rd_data combinationally for rd_addr
// Notes:   one instruction in flight; accept cycle then execute cycle
`timescale 1ns/1ps
`default_nettype none
`include "sme_defines.svh"

module sme_exec (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [2:0]  instr_op,
  input  wire logic [6:0]  file_addr,
  input  wire logic        dest_sel,
  input  wire logic        ptr_sel,
  input  wire logic [1:0]  pointer_update_kind,
  input  wire logic        rel_mode,
  input  wire logic [5:0]  rel_offset,
  output logic             rd_en,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             wr_en,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic [7:0]       acc,
  output logic             carry_flag,
  output logic             zero_flag,
  output logic [15:0]      ptr0_value,
  output logic [15:0]      ptr1_value,
  output logic             done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sme_pkg::sme_state_type state_reg;
  sme_pkg::sme_state_type state_next;
  sme_pkg::sme_op_type    op_reg;
  sme_pkg::sme_op_type    op_next;
  logic                   dest_reg;
  logic                   dest_next;
  logic [15:0]            eff_addr_reg;
  logic [15:0]            eff_addr_next;
  logic [7:0]             acc_reg;
  logic [7:0]             acc_next;
  logic                   carry_reg;
  logic                   carry_next;
  logic                   zero_reg;
  logic                   zero_next;
  logic [15:0]            ptr_reg [2];
  logic [15:0]            ptr_next [2];
  logic                   wr_en_reg;
  logic                   wr_en_next;
  logic [15:0]            wr_addr_reg;
  logic [15:0]            wr_addr_next;
  logic [7:0]             wr_data_reg;
  logic [7:0]             wr_data_next;
  logic                   done_reg;
  logic                   done_next;
  logic [7:0]             result;
  logic [15:0]            sel_ptr;
  logic [15:0]            stepped_ptr;
  logic [15:0]            offset_ext;

  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction

  // matches the file operand against an indirect port
  function automatic logic is_port(input logic [6:0] addr, input logic which);
    is_port = (addr == (which ? `SME_INDIRECT_PORT1 : `SME_INDIRECT_PORT0));
  endfunction

  assign sel_ptr    = ptr_sel ? ptr_reg[1] : ptr_reg[0];
  assign offset_ext = {{10{rel_offset[5]}}, rel_offset};

  assign stepped_ptr = pointer_update_kind[0] ? sel_ptr - `SME_PTR_STEP
                                              : sel_ptr + `SME_PTR_STEP;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    dest_next     = dest_reg;
    eff_addr_next = eff_addr_reg;
    acc_next      = acc_reg;
    carry_next    = carry_reg;
    zero_next     = zero_reg;
    ptr_next[0]   = ptr_reg[0];
    ptr_next[1]   = ptr_reg[1];
    wr_en_next    = 1'b0;
    wr_addr_next  = wr_addr_reg;
    wr_data_next  = wr_data_reg;
    done_next     = 1'b0;
    result        = rd_data;
    unique case (state_reg)
      sme_pkg::SME_ST_IDLE: begin
        if (instr_valid) begin
          state_next = sme_pkg::SME_ST_EXEC;
          op_next    = sme_pkg::sme_op_type'(instr_op);
          dest_next  = dest_sel;
          if (sme_pkg::sme_op_type'(instr_op) == sme_pkg::SME_OP_LOAD_ACC_INDIRECT) begin
            if (rel_mode) begin
              eff_addr_next = sel_ptr + offset_ext;
            end else begin
              eff_addr_next = pointer_update_kind[1] ? sel_ptr : stepped_ptr;
              ptr_next[ptr_sel] = stepped_ptr;
            end
          end else if (is_port(file_addr, 1'b0)) begin
            eff_addr_next = ptr_reg[0];
          end else if (is_port(file_addr, 1'b1)) begin
            eff_addr_next = ptr_reg[1];
          end else begin
            eff_addr_next = {9'h000, file_addr};
          end
        end
      end
      sme_pkg::SME_ST_EXEC: begin
        state_next = sme_pkg::SME_ST_IDLE;
        done_next  = 1'b1;
        unique case (op_reg)
          sme_pkg::SME_OP_OR_ACC_INTO_FILE: begin
            result = acc_reg | rd_data;
          end
          sme_pkg::SME_OP_SHIFT_LEFT_LOGICAL: begin
            result = {rd_data[6:0], 1'b0};
            carry_next = rd_data[7];
          end
          sme_pkg::SME_OP_SHIFT_RIGHT_LOGICAL: begin
            result = {1'b0, rd_data[7:1]};
            carry_next = rd_data[0];
          end
          sme_pkg::SME_OP_COPY_FILE_OPERAND: begin
            result = rd_data;
          end
          default: begin
            result = rd_data;
          end
        endcase
        zero_next = is_zero(result);
        if (op_reg != sme_pkg::SME_OP_LOAD_ACC_INDIRECT && dest_reg == `SME_DEST_FILE) begin
          wr_en_next   = 1'b1;
          wr_addr_next = eff_addr_reg;
          wr_data_next = result;
        end else begin
          acc_next = result;
        end
      end
      default: begin
        state_next = sme_pkg::SME_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= sme_pkg::SME_ST_IDLE;
      op_reg       <= sme_pkg::SME_OP_OR_ACC_INTO_FILE;
      dest_reg     <= `SME_DEST_ACC;
      eff_addr_reg <= `SME_PTR_RESET;
      acc_reg      <= `SME_ACC_RESET;
      carry_reg    <= 1'b0;
      zero_reg     <= 1'b0;
      ptr_reg[0]   <= `SME_PTR_RESET;
      ptr_reg[1]   <= `SME_PTR_RESET;
      wr_en_reg    <= 1'b0;
      wr_addr_reg  <= `SME_PTR_RESET;
      wr_data_reg  <= `SME_ACC_RESET;
      done_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      dest_reg     <= dest_next;
      eff_addr_reg <= eff_addr_next;
      acc_reg      <= acc_next;
      carry_reg    <= carry_next;
      zero_reg     <= zero_next;
      ptr_reg[0]   <= ptr_next[0];
      ptr_reg[1]   <= ptr_next[1];
      wr_en_reg    <= wr_en_next;
      wr_addr_reg  <= wr_addr_next;
      wr_data_reg  <= wr_data_next;
      done_reg     <= done_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign instr_ready = (state_reg == sme_pkg::SME_ST_IDLE);
  assign rd_en       = (state_reg == sme_pkg::SME_ST_EXEC);
  assign rd_addr     = eff_addr_reg;
  assign wr_en       = wr_en_reg;
  assign wr_addr     = wr_addr_reg;
  assign wr_data     = wr_data_reg;
  assign acc         = acc_reg;
  assign carry_flag  = carry_reg;
  assign zero_flag   = zero_reg;
  assign ptr0_value  = ptr_reg[0];
  assign ptr1_value  = ptr_reg[1];
  assign done        = done_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic exec_now;
  logic accept_now;
  logic load_accept;
  assign exec_now    = (state_reg == sme_pkg::SME_ST_EXEC);
  assign accept_now  = instr_valid && instr_ready;
  assign load_accept = accept_now && (instr_op == 3'h4);

  property p_or_zero;
    @(posedge clk) disable iff (!rst_n)
    exec_now && op_reg == sme_pkg::SME_OP_OR_ACC_INTO_FILE
      |=> zero_reg == ($past(acc_reg | rd_data) == 8'h00) && $stable(carry_reg);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("or result flags wrong");

  property p_dest_file;
    @(posedge clk) disable iff (!rst_n)
    exec_now && op_reg != sme_pkg::SME_OP_LOAD_ACC_INDIRECT && dest_reg
      |=> wr_en_reg && wr_addr_reg == $past(eff_addr_reg) && $stable(acc_reg) ##1 !wr_en_reg;
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file target not written");

  property p_dest_acc;
    @(posedge clk) disable iff (!rst_n)
    exec_now && !dest_reg |=> !wr_en_reg && $stable(wr_data_reg) && $stable(wr_addr_reg);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("acc target wrote file");

  property p_shl;
    @(posedge clk) disable iff (!rst_n)
    exec_now && op_reg == sme_pkg::SME_OP_SHIFT_LEFT_LOGICAL
      |=> carry_reg == $past(rd_data[7])
          && (dest_reg ? wr_data_reg : acc_reg) == {$past(rd_data[6:0]), 1'b0};
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");

  property p_shr;
    @(posedge clk) disable iff (!rst_n)
    exec_now && op_reg == sme_pkg::SME_OP_SHIFT_RIGHT_LOGICAL
      |=> carry_reg == $past(rd_data[0])
          && (dest_reg ? wr_data_reg : acc_reg) == {1'b0, $past(rd_data[7:1])};
  endproperty
  a_shr: assert property (p_shr) else $error("right shift wrong");

  property p_load;
    @(posedge clk) disable iff (!rst_n)
    exec_now && op_reg == sme_pkg::SME_OP_LOAD_ACC_INDIRECT
      |=> acc_reg == $past(rd_data) && zero_reg == (acc_reg == 8'h00) && !wr_en_reg;
  endproperty
  a_load: assert property (p_load) else $error("indirect load wrong");

  property p_pre_inc;
    @(posedge clk) disable iff (!rst_n)
    load_accept && !rel_mode && pointer_update_kind == 2'h0 && !ptr_sel
      |=> ptr_reg[0] == $past(ptr_reg[0]) + 16'h0001 && eff_addr_reg == ptr_reg[0];
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("pre-increment wrong");

  property p_post_dec;
    @(posedge clk) disable iff (!rst_n)
    load_accept && !rel_mode && pointer_update_kind == 2'h3 && ptr_sel
      |=> ptr_reg[1] == $past(ptr_reg[1]) - 16'h0001 && eff_addr_reg == $past(ptr_reg[1]);
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

  property p_relative;
    @(posedge clk) disable iff (!rst_n)
    load_accept && rel_mode
      |=> $stable(ptr_reg[0]) && $stable(ptr_reg[1])
          && eff_addr_reg == $past(sel_ptr) + $past(offset_ext);
  endproperty
  a_relative: assert property (p_relative) else $error("relative address wrong");

  property p_port;
    @(posedge clk) disable iff (!rst_n)
    accept_now && instr_op != 3'h4 && file_addr == 7'h01 |=> eff_addr_reg == ptr_reg[1];
  endproperty
  a_port: assert property (p_port) else $error("indirect port not redirected");

  property p_flags_kept;
    @(posedge clk) disable iff (!rst_n)
    load_accept |=> $stable(carry_reg) && $stable(zero_reg) ##1 $stable(carry_reg);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("pointer step touched flags");

  property p_one_cycle;
    @(posedge clk) disable iff (!rst_n)
    accept_now |=> !instr_ready ##1 done_reg && instr_ready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("execute sequence wrong");

endmodule

`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for sme_exec
// Assumes: file array answers rd_data in the same cycle as rd_en
// Notes:   one instruction at a time; results checked after accept +2
`timescale 1ns/1ps
`default_nettype none

module tb;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        instr_valid;
  logic        instr_ready;
  logic [2:0]  instr_op;
  logic [6:0]  file_addr;
  logic        dest_sel;
  logic        ptr_sel;
  logic [1:0]  pointer_update_kind;
  logic        rel_mode;
  logic [5:0]  rel_offset;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  acc;
  logic        carry_flag;
  logic        zero_flag;
  logic [15:0] ptr0_value;
  logic [15:0] ptr1_value;
  logic        done;
  logic [7:0]  operand;
  logic [15:0] cap_addr;
  int          num_errors;
  int          n_tests;
  int          cyc;

  // file array stand-in; not selected shows inverted data
  assign rd_data = rd_en ? operand : ~operand;

  sme_exec dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .instr_valid         (instr_valid),
    .instr_ready         (instr_ready),
    .instr_op            (instr_op),
    .file_addr           (file_addr),
    .dest_sel            (dest_sel),
    .ptr_sel             (ptr_sel),
    .pointer_update_kind (pointer_update_kind),
    .rel_mode            (rel_mode),
    .rel_offset          (rel_offset),
    .rd_en               (rd_en),
    .rd_addr             (rd_addr),
    .rd_data             (rd_data),
    .wr_en               (wr_en),
    .wr_addr             (wr_addr),
    .wr_data             (wr_data),
    .acc                 (acc),
    .carry_flag          (carry_flag),
    .zero_flag           (zero_flag),
    .ptr0_value          (ptr0_value),
    .ptr1_value          (ptr1_value),
    .done                (done)
  );

  // --------------------------------------------------------------
  // clock and watchdog
  // --------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc >= 1000) begin
      num_errors++;
      summarize();
    end
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input sme_pkg::sme_op_type op, input logic [6:0] fa, input logic d,
                       input logic ps, input logic [1:0] k, input logic rm,
                       input logic [5:0] off, input logic [7:0] opnd);
    @(posedge clk);
    #1;
    instr_op = op;
    file_addr = fa;
    dest_sel = d;
    ptr_sel = ps;
    pointer_update_kind = k;
    rel_mode = rm;
    rel_offset = off;
    operand = opnd;
    instr_valid = 1'b1;
    chk(instr_ready, 16'h0001);
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    chk(instr_ready, 16'h0000);
    chk(rd_en, 16'h0001);
    cap_addr = rd_addr;
    @(posedge clk);
    #1;
    chk(done, 16'h0001);
  endtask

  // file-operand instruction; zero expected from the result
  task automatic op_file(input sme_pkg::sme_op_type op, input logic [6:0] fa, input logic d,
                         input logic [7:0] opnd, input logic [15:0] ea,
                         input logic [7:0] res, input logic c);
    logic [7:0] acc_old;
    acc_old = acc;
    issue(op, fa, d, 1'b0, 2'h0, 1'b0, 6'h00, opnd);
    chk(cap_addr, ea);
    chk(wr_en, {15'h0000, d});
    if (d) begin
      chk(wr_addr, ea);
      chk(wr_data, res);
      chk(acc, acc_old);
    end else begin
      chk(acc, res);
    end
    chk(carry_flag, c);
    chk(zero_flag, res == 8'h00);
  endtask

  // indirect load; carry must survive pointer stepping
  task automatic ld(input logic ps, input logic [1:0] k, input logic rm, input logic [5:0] off,
                    input logic [7:0] opnd, input logic [15:0] ea,
                    input logic [15:0] p0, input logic [15:0] p1);
    logic c_old;
    c_old = carry_flag;
    issue(sme_pkg::SME_OP_LOAD_ACC_INDIRECT, 7'h20, 1'b1, ps, k, rm, off, opnd);
    chk(cap_addr, ea);
    chk(acc, opnd);
    chk(zero_flag, opnd == 8'h00);
    chk(carry_flag, c_old);
    chk(wr_en, 16'h0000);
    chk(ptr0_value, p0);
    chk(ptr1_value, p1);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_or_copy();
    op_file(sme_pkg::SME_OP_COPY_FILE_OPERAND, 7'h10, 1'b0, 8'h5a, 16'h0010, 8'h5a, 1'b0);
    op_file(sme_pkg::SME_OP_OR_ACC_INTO_FILE, 7'h7f, 1'b1, 8'h81, 16'h007f, 8'hdb, 1'b0);
    op_file(sme_pkg::SME_OP_COPY_FILE_OPERAND, 7'h11, 1'b0, 8'h00, 16'h0011, 8'h00, 1'b0);
    op_file(sme_pkg::SME_OP_OR_ACC_INTO_FILE, 7'h12, 1'b0, 8'h00, 16'h0012, 8'h00, 1'b0);
    op_file(sme_pkg::SME_OP_OR_ACC_INTO_FILE, 7'h13, 1'b1, 8'h24, 16'h0013, 8'h24, 1'b0);
    op_file(sme_pkg::SME_OP_COPY_FILE_OPERAND, 7'h33, 1'b1, 8'h00, 16'h0033, 8'h00, 1'b0);
  endtask

  task automatic t_shifts();
    op_file(sme_pkg::SME_OP_SHIFT_LEFT_LOGICAL, 7'h05, 1'b1, 8'h80, 16'h0005, 8'h00, 1'b1);
    op_file(sme_pkg::SME_OP_SHIFT_LEFT_LOGICAL, 7'h06, 1'b0, 8'h41, 16'h0006, 8'h82, 1'b0);
    op_file(sme_pkg::SME_OP_SHIFT_RIGHT_LOGICAL, 7'h07, 1'b0, 8'h01, 16'h0007, 8'h00, 1'b1);
    op_file(sme_pkg::SME_OP_SHIFT_RIGHT_LOGICAL, 7'h08, 1'b1, 8'h82, 16'h0008, 8'h41, 1'b0);
    op_file(sme_pkg::SME_OP_SHIFT_RIGHT_LOGICAL, 7'h0a, 1'b1, 8'h01, 16'h000a, 8'h00, 1'b1);
    op_file(sme_pkg::SME_OP_OR_ACC_INTO_FILE, 7'h09, 1'b1, 8'hf0, 16'h0009, 8'hf0, 1'b1);
  endtask

  task automatic t_loads();
    ld(1'b0, 2'h1, 1'b0, 6'h00, 8'h00, 16'hffff, 16'hffff, 16'h0000);
    ld(1'b0, 2'h2, 1'b0, 6'h00, 8'h9c, 16'hffff, 16'h0000, 16'h0000);
    ld(1'b0, 2'h0, 1'b0, 6'h00, 8'h3c, 16'h0001, 16'h0001, 16'h0000);
    ld(1'b0, 2'h3, 1'b0, 6'h00, 8'h00, 16'h0001, 16'h0000, 16'h0000);
    ld(1'b1, 2'h0, 1'b0, 6'h00, 8'h11, 16'h0001, 16'h0000, 16'h0001);
    ld(1'b1, 2'h1, 1'b1, 6'h20, 8'h22, 16'hffe1, 16'h0000, 16'h0001);
    ld(1'b1, 2'h0, 1'b1, 6'h1f, 8'h00, 16'h0020, 16'h0000, 16'h0001);
  endtask

  task automatic t_port();
    ld(1'b0, 2'h1, 1'b0, 6'h00, 8'h55, 16'hffff, 16'hffff, 16'h0001);
    ld(1'b1, 2'h2, 1'b0, 6'h00, 8'h44, 16'h0001, 16'hffff, 16'h0002);
    op_file(sme_pkg::SME_OP_COPY_FILE_OPERAND, 7'h01, 1'b1, 8'h77, 16'h0002, 8'h77, 1'b1);
    op_file(sme_pkg::SME_OP_COPY_FILE_OPERAND, 7'h00, 1'b0, 8'h66, 16'hffff, 8'h66, 1'b1);
    chk(ptr0_value, 16'hffff);
    chk(ptr1_value, 16'h0002);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_op = 3'h0;
    file_addr = 7'h00;
    dest_sel = 1'b0;
    ptr_sel = 1'b0;
    pointer_update_kind = 2'h0;
    rel_mode = 1'b0;
    rel_offset = 6'h00;
    operand = 8'h00;
    cap_addr = 16'h0000;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_or_copy();
    t_shifts();
    t_loads();
    t_port();
    summarize();
  end
endmodule

`default_nettype wire
